/* hw/hbd_bridge_ctrl.sv */
// H-bridge drive control: decode, sleep, protection, current regulation, APB
`timescale 1ns/1ps
module hbd_bridge_ctrl
  import hbd_pkg::*;
#(
  parameter logic [TMR_W-1:0] WAKE_TICKS_P  = 16'(WAKE_TICKS),
  parameter logic [TMR_W-1:0] RETRY_TICKS_P = 16'(RETRY_TICKS)
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Logic input pins
  input  wire logic        bridge_enable,
  input  wire logic        direction_in_a,
  input  wire logic        direction_in_b,
  input  wire logic        sleep_n,
  input  wire logic [1:0]  decay_select,
  input  wire logic [3:0]  trip_level_select,
  // Analog comparator results
  input  wire logic        trip_compare,
  input  wire logic        overcurrent_guard_det,
  input  wire logic        thermal_cutout_det,
  input  wire logic        supply_low_lockout_det,
  // Bridge switch controls
  output logic             node_a_hs_on,
  output logic             node_a_ls_on,
  output logic             node_b_hs_on,
  output logic             node_b_ls_on,
  // Sense replica gates and trip level
  output logic             sense_replica_a,
  output logic             sense_replica_b,
  output logic      [9:0]  trip_current_level,
  // Open-drain status pins
  output logic             fault_n_o,
  output logic             fault_n_oe,
  output logic             regulation_active_monitor_n_o,
  output logic             regulation_active_monitor_n_oe,
  // Power domain controls
  output logic             charge_pump_en,
  output logic             bias_en
);
  // Synchroniser stages for all pins
  logic [13:0] sync1_reg;
  logic [13:0] sync2_reg;
  // Synchronised pin values
  logic        en_s, dir_a_s, dir_b_s, sleep_s, trip_s, ocp_s, therm_s, uv_s;
  logic [1:0]  decay_s;
  logic [3:0]  trip_level_select_s;
  // Reference tick divider
  logic [TICK_W-1:0] tick_cnt_reg;
  logic              tick_reg;
  // Software registers
  logic [31:0]      ctrl_reg;
  logic [TMR_W-1:0] off_reg;
  logic [TMR_W-1:0] blank_reg;
  logic [31:0]      prdata_reg;
  // Timers
  logic [TMR_W-1:0] wake_cnt, retry_cnt, off_cnt, blank_cnt;
  logic             wake_busy, retry_busy, off_busy, blank_busy;
  logic             wake_load, retry_load, off_load, blank_load;
  logic [TMR_W-1:0] off_load_val;
  // Bridge state
  logic [3:0]  drive_reg;
  logic [3:0]  drive_next;
  logic [1:0]  dir_prev_reg;
  logic [1:0]  dir_cap_reg;
  logic        awake_ready, prot, block, reg_en, trip_start, dir_change;
  logic        fast_phase;
  logic [31:0] fast_full;
  logic [16:0] fast_ticks;
  // Bus decode
  logic        wr_en, rd_setup, addr_ok;
  logic [31:0] status_word, rd_word, wr_word;

  // Two-flop synchroniser; reset low means asleep until the pin is driven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {supply_low_lockout_det, thermal_cutout_det, overcurrent_guard_det, trip_compare,
                    trip_level_select, decay_select, sleep_n, direction_in_b,
                    direction_in_a, bridge_enable};
      sync2_reg <= sync1_reg;
    end
  end

  // Unpack the second stage
  assign {uv_s, therm_s, ocp_s, trip_s, trip_level_select_s, decay_s, sleep_s, dir_b_s, dir_a_s, en_s} =
    sync2_reg;

  // Reference tick: one pulse every TICK_CYCLES clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg     <= 1'b0;
    end
  end

  // Wake timer held loaded while asleep, runs out after release
  assign wake_load   = !sleep_s;
  assign awake_ready = sleep_s && !wake_busy;

  hbd_timer #(.W(TMR_W)) u_wake (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick_reg),
    .load     (wake_load),
    .load_val (WAKE_TICKS_P),
    .count    (wake_cnt),
    .busy     (wake_busy)
  );

  // Overcurrent retry: start a high-impedance hold, repeat while it persists
  assign retry_load = ocp_s && !retry_busy;

  hbd_timer #(.W(TMR_W)) u_retry (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick_reg),
    .load     (retry_load),
    .load_val (RETRY_TICKS_P),
    .count    (retry_cnt),
    .busy     (retry_busy)
  );

  // Conditions that stop the regulation loop
  assign reg_en = ctrl_reg[CTRL_REG_EN_BIT];
  assign prot   = therm_s || uv_s || ocp_s || retry_busy;
  assign block  = !awake_ready || prot || !en_s || !reg_en;

  // Trip is ignored while blanking and only while the bridge energises
  assign dir_change = ({dir_a_s, dir_b_s} != dir_prev_reg);
  assign trip_start = trip_s && !blank_busy && !off_busy && !block &&
                      ((drive_reg == DRV_FWD) || (drive_reg == DRV_REV));

  // Off interval loads on trip, restarts on direction change, clears when blocked
  assign off_load     = trip_start || (off_busy && (dir_change || block));
  assign off_load_val = block ? '0 : off_reg;

  hbd_timer #(.W(TMR_W)) u_off (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick_reg),
    .load     (off_load),
    .load_val (off_load_val),
    .count    (off_cnt),
    .busy     (off_busy)
  );

  // Fast share of the off interval from the decay select
  always_comb begin
    fast_full = 32'h0;
    unique case (decay_s)
      DECAY_SLOW:  fast_full = 32'h0;
      DECAY_MIX30: fast_full = 32'(off_reg) * 32'(PCT_MIX30) / 32'(PCT_FULL);
      DECAY_MIX60: fast_full = 32'(off_reg) * 32'(PCT_MIX60) / 32'(PCT_FULL);
      DECAY_FAST:  fast_full = 32'(off_reg);
    endcase
  end

  // Fast part comes first: fast while elapsed ticks are below the share
  assign fast_ticks = fast_full[16:0];
  assign fast_phase = off_busy && (({1'b0, off_cnt} + fast_ticks) > {1'b0, off_reg});

  // Direction history for change detection and captured drive at trip
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_prev_reg <= 2'h0;
      dir_cap_reg  <= 2'h0;
    end else begin
      dir_prev_reg <= {dir_a_s, dir_b_s};
      if (off_load) begin
        dir_cap_reg <= {dir_a_s, dir_b_s};
      end
    end
  end

  // Output switch pattern by priority: sleep, protection, enable, loop, decode
  always_comb begin
    drive_next = DRV_HIZ;
    if (!awake_ready) begin
      drive_next = DRV_HIZ;
    end else if (prot) begin
      drive_next = DRV_HIZ;
    end else if (!en_s) begin
      drive_next = DRV_HIZ;
    end else if (off_busy) begin
      // Fast decay reverses the bridge, slow decay grounds both terminals
      if (fast_phase && (dir_cap_reg == 2'h2)) begin
        drive_next = DRV_REV;
      end else if (fast_phase && (dir_cap_reg == 2'h1)) begin
        drive_next = DRV_FWD;
      end else begin
        drive_next = DRV_BRAKE_LO;
      end
    end else begin
      unique case ({dir_a_s, dir_b_s})
        2'h0: drive_next = DRV_BRAKE_LO;
        2'h2: drive_next = DRV_FWD;
        2'h1: drive_next = DRV_REV;
        2'h3: drive_next = DRV_BRAKE_HI;
      endcase
    end
  end

  // Any change of switch pattern is a switching event
  assign blank_load = (drive_next != drive_reg);

  hbd_timer #(.W(TMR_W)) u_blank (
    .pclk     (pclk),
    .presetn  (presetn),
    .tick     (tick_reg),
    .load     (blank_load),
    .load_val (blank_reg),
    .count    (blank_cnt),
    .busy     (blank_busy)
  );

  // Registered switch controls and sense gates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_reg       <= DRV_HIZ;
      sense_replica_a <= 1'b0;
      sense_replica_b <= 1'b0;
    end else begin
      drive_reg       <= drive_next;
      sense_replica_a <= drive_next[2] && !blank_busy && !blank_load;
      sense_replica_b <= drive_next[0] && !blank_busy && !blank_load;
    end
  end

  assign {node_a_hs_on, node_a_ls_on, node_b_hs_on, node_b_ls_on} = drive_reg;

  // Open-drain pins, trip level and power controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_n_oe                     <= 1'b0;
      regulation_active_monitor_n_oe <= 1'b0;
      trip_current_level             <= 10'h000;
      charge_pump_en                 <= 1'b0;
      bias_en                        <= 1'b0;
    end else begin
      fault_n_oe                     <= therm_s || uv_s || ocp_s || retry_busy;
      regulation_active_monitor_n_oe <= off_busy;
      trip_current_level             <= TRIP_PERMILLE[trip_level_select_s];
      charge_pump_en                 <= sleep_s;
      bias_en                        <= sleep_s;
    end
  end

  // Open-drain pins only ever pull low
  assign fault_n_o                     = 1'b0;
  assign regulation_active_monitor_n_o = 1'b0;

  // Byte-lane merge for writes
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Write word: current contents of the addressed register merged with the new lanes
  assign wr_word = merge_bytes(rd_word, pwdata, pstrb);

  // Bus decode
  assign addr_ok  = (paddr == CTRL_OFS) || (paddr == OFF_OFS) ||
                    (paddr == BLANK_OFS) || (paddr == STATUS_OFS);
  assign wr_en    = psel && penable && pwrite && addr_ok;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !addr_ok;

  // Writable registers; status writes are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg  <= CTRL_RST;
      off_reg   <= OFF_TICKS_RST;
      blank_reg <= BLANK_TICKS_RST;
    end else if (wr_en) begin
      unique case (paddr)
        CTRL_OFS:  ctrl_reg  <= wr_word & CTRL_RST;
        OFF_OFS:   off_reg   <= wr_word[TMR_W-1:0];
        BLANK_OFS: blank_reg <= wr_word[TMR_W-1:0];
        default:   ctrl_reg  <= ctrl_reg;
      endcase
    end
  end

  // Status word: fields from bit 31 downward as listed
  assign status_word = {6'h00, trip_current_level, 2'h0, trip_level_select_s, decay_s, blank_busy,
                        fast_phase, off_busy, retry_busy, uv_s, therm_s, !sleep_s,
                        awake_ready};

  // Read mux, unused bits read as zero
  always_comb begin
    rd_word = 32'h0;
    if (paddr == CTRL_OFS) begin
      rd_word = ctrl_reg;
    end else if (paddr == OFF_OFS) begin
      rd_word = {16'h0, off_reg};
    end else if (paddr == BLANK_OFS) begin
      rd_word = {16'h0, blank_reg};
    end else if (paddr == STATUS_OFS) begin
      rd_word = status_word;
    end
  end

  // Read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (rd_setup) begin
      prdata_reg <= rd_word;
    end
  end

  assign prdata = prdata_reg;

  // Checks on the bridge behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_en_low_hiz;
    !en_s |=> (drive_reg == DRV_HIZ);
  endproperty
  a_en_low_hiz: assert property (p_en_low_hiz) else $error("enable low but bridge driven");

  property p_brake_low;
    awake_ready && !prot && en_s && !off_busy && !dir_a_s && !dir_b_s
      |=> (drive_reg == DRV_BRAKE_LO);
  endproperty
  a_brake_low: assert property (p_brake_low) else $error("low brake not driven");

  property p_forward;
    awake_ready && !prot && en_s && !off_busy && dir_a_s && !dir_b_s |=> (drive_reg == DRV_FWD);
  endproperty
  a_forward: assert property (p_forward) else $error("forward not driven");

  property p_reverse;
    awake_ready && !prot && en_s && !off_busy && !dir_a_s && dir_b_s |=> (drive_reg == DRV_REV);
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse not driven");

  property p_brake_high;
    awake_ready && !prot && en_s && !off_busy && dir_a_s && dir_b_s
      |=> (drive_reg == DRV_BRAKE_HI);
  endproperty
  a_brake_high: assert property (p_brake_high) else $error("high brake not driven");

  property p_sleep_off;
    !sleep_s |=> (drive_reg == DRV_HIZ) && !charge_pump_en && !bias_en;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("sleep left bridge powered");

  property p_wake_delay;
    $rose(sleep_s) |-> !awake_ready ##1 (drive_reg == DRV_HIZ);
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("bridge ready too early");

  property p_fault_out;
    (therm_s || uv_s || ocp_s) |=> fault_n_oe && (drive_reg == DRV_HIZ);
  endproperty
  a_fault_out: assert property (p_fault_out) else $error("fault not flagged");

  property p_trip_decay;
    trip_start |=> off_busy && (off_cnt == $past(off_reg)) ##1 regulation_active_monitor_n_oe;
  endproperty
  a_trip_decay: assert property (p_trip_decay) else $error("trip did not start off");

  property p_sense_gate;
    (sense_replica_a |-> node_a_ls_on) and (sense_replica_b |-> node_b_ls_on);
  endproperty
  a_sense_gate: assert property (p_sense_gate) else $error("sense with low side off");

  property p_blank_zero;
    blank_busy |=> !sense_replica_a && !sense_replica_b;
  endproperty
  a_blank_zero: assert property (p_blank_zero) else $error("sense during blanking");

  property p_restart;
    off_busy && dir_change && !block |=> (off_cnt == $past(off_reg));
  endproperty
  a_restart: assert property (p_restart) else $error("off not restarted");

  property p_retry_hold;
    retry_load |=> retry_busy && (retry_cnt == RETRY_TICKS_P) && (drive_reg == DRV_HIZ);
  endproperty
  a_retry_hold: assert property (p_retry_hold) else $error("retry hold not started");

  // Main scenarios
  c_trip:  cover property (trip_start);
  c_fast:  cover property (fast_phase && (drive_reg != DRV_BRAKE_LO));
  c_retry: cover property (retry_load);
  c_wake:  cover property ($rose(awake_ready));
endmodule

/* hw/hbd_pkg.sv */
// Shared constants for the H-bridge drive control block
//
// Summary of operation
// - Enable low: both nodes high impedance, coast.
// - Enable, inputs 00: both nodes low.
// - Enable, inputs 10: A high, B low.
// - Enable, inputs 01: A low, B high.
// - Enable, inputs 11: both nodes high.
// - Sleep low: outputs off, bias, pump off.
// - Floating sleep input means sleep.
// - Normal operation within 2.7ms after wake.
// - Fault output asserted on any protection.
// - Thermal or undervoltage: bridge off until cleared.
// - Trip current exceeded: force decay, fixed interval.
// - Monitor output asserted while loop controls bridge.
// - Sense replica only while low side on.
// - Sense replica zero during blanking.
// - Slow decay turns on both low sides.
// - Decay select: slow, 30%, 60%, fast.
// - Trip level table, 100% down to 0%.
// - Direction input change restarts off interval.
// - Overcurrent: off 3ms, retry, repeat.
package hbd_pkg;
  // Clock and reference tick
  localparam int CLK_MHZ       = 200;
  localparam int TICK_NS       = 100;
  localparam int TICK_CYCLES   = TICK_NS * CLK_MHZ / 1000;
  localparam int TICK_W        = 8;
  // Documented durations in their own units
  localparam int WAKE_TIME_US  = 2700;
  localparam int RETRY_TIME_US = 3000;
  localparam int OFF_TIME_NS   = 20000;
  localparam int BLANK_TIME_NS = 2500;
  // Durations as tick counts: longest time rounds down, least time up
  localparam int WAKE_TICKS    = WAKE_TIME_US * 1000 / TICK_NS;
  localparam int RETRY_TICKS   = (RETRY_TIME_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int TMR_W         = 16;
  localparam logic [TMR_W-1:0] OFF_TICKS_RST   = 16'((OFF_TIME_NS + TICK_NS - 1) / TICK_NS);
  localparam logic [TMR_W-1:0] BLANK_TICKS_RST = 16'((BLANK_TIME_NS + TICK_NS - 1) / TICK_NS);
  // Register byte offsets
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] OFF_OFS    = 12'h004;
  localparam logic [11:0] BLANK_OFS  = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00c;
  // Control register layout and reset
  localparam int          CTRL_REG_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0001;
  // Decay select codes and fast share in percent
  localparam logic [1:0]  DECAY_SLOW  = 2'h0;
  localparam logic [1:0]  DECAY_MIX30 = 2'h1;
  localparam logic [1:0]  DECAY_MIX60 = 2'h2;
  localparam logic [1:0]  DECAY_FAST  = 2'h3;
  localparam int          PCT_MIX30   = 30;
  localparam int          PCT_MIX60   = 60;
  localparam int          PCT_FULL    = 100;
  // Switch pattern {a_hs, a_ls, b_hs, b_ls}
  localparam logic [3:0]  DRV_HIZ      = 4'h0;
  localparam logic [3:0]  DRV_BRAKE_LO = 4'h5;
  localparam logic [3:0]  DRV_FWD      = 4'h9;
  localparam logic [3:0]  DRV_REV      = 4'h6;
  localparam logic [3:0]  DRV_BRAKE_HI = 4'ha;
  // Trip level in per mille of full scale, code 15 leftmost
  localparam logic [15:0][9:0] TRIP_PERMILLE = {
    10'h000, 10'h066, 10'h0cd, 10'h133, 10'h199, 10'h1f8, 10'h24f, 10'h29d,
    10'h2e4, 10'h32b, 10'h362, 10'h391, 10'h3b9, 10'h3d0, 10'h3e0, 10'h3e8};
endpackage

/* hw/hbd_timer.sv */
// Down counter stepped by the reference tick
`timescale 1ns/1ps
module hbd_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Status
  output logic      [W-1:0] count,
  output logic              busy
);
  // Load wins over counting; stops at zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (tick && busy) begin
      count <= count - 1'b1;
    end
  end

  // Running while nonzero
  assign busy = (count != '0);
endmodule

/* test/hbd_pad_model.sv */
// Controller-side pads: sleep pulldown and open-drain pull-ups
`timescale 1ns/1ps
module hbd_pad_model (
  // Controller drive of the sleep line
  input  wire logic sleep_drv,
  input  wire logic sleep_oe,
  // Device open-drain pins
  input  wire logic fault_n_o,
  input  wire logic fault_n_oe,
  input  wire logic mon_n_o,
  input  wire logic mon_n_oe,
  // Resolved line levels
  output logic      sleep_n,
  output logic      fault_n,
  output logic      mon_n
);
  // Undriven sleep line falls to the pulldown level
  assign sleep_n = sleep_oe ? sleep_drv : 1'b0;
  // Released open-drain lines float up to the pull-ups
  assign fault_n = fault_n_oe ? fault_n_o : 1'b1;
  assign mon_n   = mon_n_oe ? mon_n_o : 1'b1;
endmodule

/* test/hbridge_drive_control_test.sv */
// Self-checking bench for the H-bridge drive control block
`timescale 1ns/1ps
module hbridge_drive_control_test;
  import hbd_pkg::*;
  // APB side
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  // Pins, sensors and outputs
  logic        en = 1'b0, da = 1'b0, db = 1'b0, slp_drv = 1'b0, slp_oe = 1'b0;
  logic        trip = 1'b0, overcurrent_guard = 1'b0, thermal_cutout = 1'b0, supply_low_lockout = 1'b0;
  logic [1:0]  dsel = 2'h0;
  logic [3:0]  tsel = 4'h0;
  logic        sleep_n, ahs, als, bhs, bls, sa, sb, fo, foe, mo, moe, cp, bias, fault_n, mon_n;
  logic [9:0]  lvl;
  wire  [3:0]  pat = {ahs, als, bhs, bls};
  // Bookkeeping and expected trip levels
  int          mismatches = 0, total_checks = 0, cyc = 0;
  logic [9:0]  lvl_tab [16] = '{10'h3e8, 10'h3e0, 10'h3d0, 10'h3b9, 10'h391, 10'h362,
    10'h32b, 10'h2e4, 10'h29d, 10'h24f, 10'h1f8, 10'h199, 10'h133, 10'h0cd, 10'h066, 10'h000};

  // Short wake and retry counts keep the run brief
  hbd_bridge_ctrl #(.WAKE_TICKS_P(16'h0014), .RETRY_TICKS_P(16'h001e)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bridge_enable(en), .direction_in_a(da), .direction_in_b(db),
    .sleep_n(sleep_n), .decay_select(dsel), .trip_level_select(tsel), .trip_compare(trip),
    .overcurrent_guard_det(overcurrent_guard), .thermal_cutout_det(thermal_cutout), .supply_low_lockout_det(supply_low_lockout),
    .node_a_hs_on(ahs), .node_a_ls_on(als), .node_b_hs_on(bhs), .node_b_ls_on(bls),
    .sense_replica_a(sa), .sense_replica_b(sb), .trip_current_level(lvl),
    .fault_n_o(fo), .fault_n_oe(foe), .regulation_active_monitor_n_o(mo),
    .regulation_active_monitor_n_oe(moe), .charge_pump_en(cp), .bias_en(bias));

  // Pads of the external controller
  hbd_pad_model pads (.sleep_drv(slp_drv), .sleep_oe(slp_oe), .fault_n_o(fo),
    .fault_n_oe(foe), .mon_n_o(mo), .mon_n_oe(moe), .sleep_n(sleep_n), .fault_n(fault_n),
    .mon_n(mon_n));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      end_of_test();
    end
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; read data and error taken at the completing edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait a number of clocks
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Set the three bridge control pins and let them pass the synchroniser
  task automatic pins(input logic e, input logic a, input logic b);
    @(posedge pclk);
    en <= e;
    da <= a;
    db <= b;
    wt(6);
  endtask

  // Expected switch pattern from enable and direction inputs
  function automatic logic [3:0] expd(input logic e, input logic a, input logic b);
    if (!e) return DRV_HIZ;
    case ({a, b})
      2'b00:   return DRV_BRAKE_LO;
      2'b10:   return DRV_FWD;
      2'b01:   return DRV_REV;
      default: return DRV_BRAKE_HI;
    endcase
  endfunction

  // Closing report
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    wt(3);
    presetn <= 1'b1;
    apb(1'b0, OFF_OFS, 32'h0);
    chk(rd, 32'h0000_00c8);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, OFF_OFS, 32'h0000_000a);
    apb(1'b0, OFF_OFS, 32'h0);
    chk(rd, 32'h0000_000a);
    apb(1'b1, BLANK_OFS, 32'h0000_0002);
    $display("Test registers done");
    // Floating sleep line keeps the bridge off
    pins(1'b1, 1'b1, 1'b0);
    chk({pat, cp, bias}, {DRV_HIZ, 2'b00});
    slp_oe  <= 1'b1;
    slp_drv <= 1'b1;
    wt(480);
    chk({pat, cp, bias}, {DRV_FWD, 2'b11});
    $display("Test sleep done");
    // Enable changes only twice here; speed control stays on the direction inputs
    for (int i = 0; i < 8; i++) begin
      pins(i[2], i[1], i[0]);
      chk(pat, expd(i[2], i[1], i[0]));
    end
    pins(1'b1, 1'b1, 1'b0);
    chk({sa, sb}, 2'b00);
    wt(100);
    chk({sa, sb}, 2'b01);
    $display("Test decode done");
    for (int d = 0; d < 4; d++) begin
      dsel <= d[1:0];
      wt(100);
      trip <= 1'b1;
      wt(8);
      trip <= 1'b0;
      chk(pat, (d == 0) ? DRV_BRAKE_LO : DRV_REV);
      chk(mon_n, 1'b0);
      wt(260);
      chk({pat, mon_n}, {DRV_FWD, 1'b1});
    end
    // Inputs reversed inside the off interval restart it and flip the fast drive
    trip <= 1'b1;
    wt(8);
    trip <= 1'b0;
    pins(1'b1, 1'b0, 1'b1);
    chk({pat, mon_n}, {DRV_FWD, 1'b0});
    wt(260);
    chk({pat, mon_n}, {DRV_REV, 1'b1});
    wt(100);
    chk({sa, sb}, 2'b10);
    pins(1'b1, 1'b1, 1'b0);
    $display("Test regulation done");
    for (int c = 0; c < 16; c++) begin
      tsel <= c[3:0];
      wt(5);
      chk(lvl, lvl_tab[c]);
    end
    for (int k = 0; k < 2; k++) begin
      thermal_cutout  <= (k == 0);
      supply_low_lockout <= (k == 1);
      wt(6);
      chk({pat, fault_n}, {DRV_HIZ, 1'b0});
      thermal_cutout  <= 1'b0;
      supply_low_lockout <= 1'b0;
      wt(6);
      chk({pat, fault_n}, {DRV_FWD, 1'b1});
    end
    overcurrent_guard <= 1'b1;
    wt(6);
    overcurrent_guard <= 1'b0;
    chk({pat, fault_n}, {DRV_HIZ, 1'b0});
    wt(500);
    chk(pat, DRV_HIZ);
    wt(200);
    chk(pat, DRV_FWD);
    slp_drv <= 1'b0;
    wt(6);
    chk({pat, cp, bias}, {DRV_HIZ, 2'b00});
    $display("Test protection done");
    end_of_test();
  end
endmodule
